// ---- src/bit_bucket_pkg.sv ----
// Shared constants for the bit bucket descriptor decoder
package bit_bucket_pkg;
    // ------------------------------------------------------------
    // Descriptor layout
    // ------------------------------------------------------------
    localparam int DESC_BITS      = 128;
    localparam int COUNT_LSB      = 64;
    localparam int COUNT_MSB      = 95;
    localparam int ZERO_LSB       = 120;
    localparam int ZERO_MSB       = 123;
    localparam int TYPE_LSB       = 124;
    localparam int TYPE_MSB       = 127;
    localparam logic [3:0] TYPE_DATA_BLOCK  = 4'h0;
    localparam logic [3:0] TYPE_BIT_BUCKET  = 4'h1;
    localparam logic [3:0] TYPE_SEGMENT     = 4'h2;
    localparam logic [3:0] TYPE_LAST_SEG    = 4'h3;
    localparam logic [3:0] TYPE_RSVD_LO     = 4'h4;
    localparam logic [3:0] TYPE_RSVD_HI     = 4'hE;
    localparam logic [3:0] ZERO_FIELD_VALUE = 4'h0;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CONTROL   = 4'h0;
    localparam logic [3:0] REG_STATUS    = 4'h4;
    localparam logic [3:0] REG_IRQ_STAT  = 4'h8;
    localparam logic [3:0] REG_IRQ_MASK  = 4'hC;
    localparam int CTRL_DEST_BIT = 0;
    localparam int IRQ_DONE_BIT  = 0;
    localparam int IRQ_ERR_BIT   = 1;
    localparam logic [31:0] RESET_CONTROL = 32'h0000_0000;
    localparam logic [1:0]  RESET_MASK    = 2'h0;
    localparam logic [31:0] RESET_COUNT   = 32'h0000_0000;
endpackage

// ---- src/discard_counter.sv ----
// Down counter that drops source bytes one beat at a time
`timescale 1ns/100ps
module discard_counter #(
    parameter int COUNT_W = 32
) (
    input  wire logic               ref_clk,
    input  wire logic               reset,
    input  wire logic               load,
    input  wire logic [COUNT_W-1:0] load_count,
    input  wire logic               src_valid,
    output logic                    busy,
    output logic [COUNT_W-1:0]      remain
);
    logic [COUNT_W-1:0] count_q;
    logic [COUNT_W-1:0] count_d;
    wire                step = src_valid && (count_q != '0);

    assign count_d = load ? load_count : (step ? count_q - 1'b1 : count_q);
    assign busy    = (count_q != '0);
    assign remain  = count_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end
endmodule

// ---- src/sgl_bit_bucket_decoder.sv ----
// Bit bucket descriptor decoder and source byte discarder
`timescale 1ns/100ps
module sgl_bit_bucket_decoder #(
    parameter int COUNT_W = 32
) (
    input  wire logic         ref_clk,
    input  wire logic         reset,
    input  wire logic [3:0]   reg_addr,
    input  wire logic [31:0]  reg_wdata,
    input  wire logic         reg_write,
    input  wire logic         reg_read,
    output logic [31:0]       reg_rdata,
    input  wire logic         desc_valid,
    input  wire logic [127:0] desc_data,
    output logic              desc_ready,
    output logic              desc_done,
    output logic              desc_error,
    output logic              desc_is_bucket,
    input  wire logic         src_valid,
    input  wire logic [7:0]   src_byte,
    output logic              src_ready,
    output logic              out_valid,
    output logic [7:0]        out_byte,
    output logic              irq
);
    // ------------------------------------------------------------
    // Descriptor field decode
    // ------------------------------------------------------------
    wire [3:0] type_code = desc_data[bit_bucket_pkg::TYPE_MSB:bit_bucket_pkg::TYPE_LSB];
    wire [3:0] zero_fld  = desc_data[bit_bucket_pkg::ZERO_MSB:bit_bucket_pkg::ZERO_LSB];
    // Bytes 7:0 and 14:12 are never looked at
    wire [COUNT_W-1:0] count_fld =
        desc_data[bit_bucket_pkg::COUNT_LSB +: COUNT_W];

    wire is_bucket  = (type_code == bit_bucket_pkg::TYPE_BIT_BUCKET);
    wire zero_bad   = is_bucket && (zero_fld != bit_bucket_pkg::ZERO_FIELD_VALUE);
    wire type_rsvd  = (type_code >= bit_bucket_pkg::TYPE_RSVD_LO) &&
                      (type_code <= bit_bucket_pkg::TYPE_RSVD_HI);
    wire desc_bad   = zero_bad || type_rsvd;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic        dest_mode_q;
    logic [1:0]  irq_stat_q;
    logic [1:0]  irq_stat_d;
    logic [1:0]  irq_mask_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    wire wr_ctrl = reg_write && (reg_addr == bit_bucket_pkg::REG_CONTROL);
    wire wr_stat = reg_write && (reg_addr == bit_bucket_pkg::REG_IRQ_STAT);
    wire wr_mask = reg_write && (reg_addr == bit_bucket_pkg::REG_IRQ_MASK);

    // ------------------------------------------------------------
    // Descriptor handshake
    // ------------------------------------------------------------
    logic done_q;
    logic err_q;
    logic bucket_q;
    logic out_valid_q;
    logic [7:0] out_byte_q;
    logic [COUNT_W-1:0] remain;
    logic busy;
    logic ready_q;

    // Descriptors are taken only when no discard is pending
    wire take = desc_valid && !busy;
    // Only a good bucket descriptor in destination mode loads a count
    wire load = take && is_bucket && !desc_bad && dest_mode_q;
    // A zero count loads zero: nothing is dropped, no error
    wire [COUNT_W-1:0] load_count = count_fld;

    discard_counter #(
        .COUNT_W    (COUNT_W)
    ) u_discard (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .load       (load),
        .load_count (load_count),
        .src_valid  (src_valid),
        .busy       (busy),
        .remain     (remain)
    );

    // Bytes are swallowed while the count runs, else passed on
    wire pass_now = src_valid && !busy;
    // Readiness one cycle ahead, so the port comes from a flip-flop
    wire ready_d  = load ? (load_count == '0) :
                    ((remain == '0) || (src_valid && (remain == COUNT_W'(1))));

    assign desc_ready = ready_q;
    assign src_ready  = 1'b1;
    assign desc_done      = done_q;
    assign desc_error     = err_q;
    assign desc_is_bucket = bucket_q;
    assign out_valid      = out_valid_q;
    assign out_byte       = out_byte_q;
    assign reg_rdata      = rdata_q;

    // ------------------------------------------------------------
    // Interrupt status: set wins over write-one clear
    // ------------------------------------------------------------
    wire [1:0] irq_events = {take && desc_bad, take && !desc_bad};
    // New mask acts at once, so irq never lags a mask write
    wire [1:0] irq_mask_d = wr_mask ? reg_wdata[1:0] : irq_mask_q;
    assign irq_stat_d = (irq_stat_q & ~(wr_stat ? reg_wdata[1:0] : 2'h0)) | irq_events;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    wire [31:0] rd_ctrl = {31'h0, dest_mode_q};
    wire [31:0] rd_stat = 32'(remain);
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (reg_read) begin
            unique case (reg_addr)
                bit_bucket_pkg::REG_CONTROL:  rdata_d = rd_ctrl;
                bit_bucket_pkg::REG_STATUS:   rdata_d = rd_stat;
                bit_bucket_pkg::REG_IRQ_STAT: rdata_d = {30'h0, irq_stat_q};
                bit_bucket_pkg::REG_IRQ_MASK: rdata_d = {30'h0, irq_mask_q};
                default:                      rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dest_mode_q <= bit_bucket_pkg::RESET_CONTROL[bit_bucket_pkg::CTRL_DEST_BIT];
            irq_stat_q  <= 2'h0;
            irq_mask_q  <= bit_bucket_pkg::RESET_MASK;
            rdata_q     <= 32'h0000_0000;
            irq         <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                dest_mode_q <= reg_wdata[bit_bucket_pkg::CTRL_DEST_BIT];
            end
            if (wr_mask) begin
                irq_mask_q <= reg_wdata[1:0];
            end
            irq_stat_q <= irq_stat_d;
            rdata_q    <= rdata_d;
            irq        <= |(irq_stat_d & irq_mask_d);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            done_q      <= 1'b0;
            err_q       <= 1'b0;
            bucket_q    <= 1'b0;
            out_valid_q <= 1'b0;
            out_byte_q  <= 8'h00;
            ready_q     <= 1'b1;
        end else begin
            done_q      <= take;
            err_q       <= take && desc_bad;
            bucket_q    <= take && is_bucket;
            out_valid_q <= pass_now;
            if (pass_now) begin
                out_byte_q <= src_byte;
            end
            ready_q     <= ready_d;
        end
    end
endmodule

// ---- verification/host_desc_mem.sv ----
// Host memory model holding one bit bucket descriptor
`timescale 1ns/100ps
module host_desc_mem (
    input  wire logic [3:0]  desc_type,
    input  wire logic [3:0]  zero_field,
    input  wire logic [31:0] count,
    output logic [127:0]     desc_word
);
    // Junk in reserved bytes, so a decoder that reads them gets caught
    assign desc_word = {desc_type, zero_field, 24'hA5C3E1, count, 64'h5A3C1E0FF0E1C3A5};
endmodule

// ---- verification/sgl_bit_bucket_props.sv ----
// Port assertions for the bit bucket decoder
`timescale 1ns/100ps
module sgl_bit_bucket_props (
    input wire logic         ref_clk,
    input wire logic         reset,
    input wire logic         desc_valid,
    input wire logic [127:0] desc_data,
    input wire logic         desc_ready,
    input wire logic         desc_done,
    input wire logic         desc_error,
    input wire logic         desc_is_bucket,
    input wire logic         src_valid,
    input wire logic [7:0]   src_byte,
    input wire logic         out_valid,
    input wire logic [7:0]   out_byte
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire       take = desc_valid && desc_ready;
    wire [3:0] dtype = desc_data[127:124];
    wire       zero_ok = desc_data[123:120] == 4'h0;
    chk_take_done: assert property (take |=> desc_done)
        else $error("no done after take");
    chk_idle_quiet: assert property (!take |=> !desc_done && !desc_error)
        else $error("flag without take");
    chk_bucket_flag: assert property (take |=> desc_is_bucket == ($past(dtype) == 4'h1))
        else $error("bucket flag wrong");
    chk_zero_error: assert property (take && dtype == 4'h1 && !zero_ok |=> desc_error)
        else $error("zero field not flagged");
    chk_rsvd_error: assert property (take && dtype >= 4'h4 && dtype <= 4'hE |=> desc_error)
        else $error("reserved type not flagged");
    chk_clean_ok: assert property (take && dtype == 4'h1 && zero_ok |=> !desc_error)
        else $error("clean descriptor flagged");
    chk_drop_silent: assert property (src_valid && !desc_ready |=> !out_valid)
        else $error("dropped byte passed");
    chk_pass_byte: assert property (src_valid && desc_ready && !desc_valid
        |=> out_valid && out_byte == $past(src_byte))
        else $error("byte not passed");
    cov_bucket: cover property (desc_done && desc_is_bucket);
    cov_drop: cover property (src_valid && !desc_ready);
    cov_error: cover property (desc_error);
endmodule

// ---- verification/tb_top.sv ----
// Directed bench for the bit bucket descriptor decoder
`timescale 1ns/100ps
module tb_top;
    logic         ref_clk = 1'h0;
    logic         reset = 1'h1;
    logic         reg_write = 1'h0;
    logic         reg_read = 1'h0;
    logic         desc_valid = 1'h0;
    logic         src_valid = 1'h0;
    logic [3:0]   reg_addr = 4'h0;
    logic [3:0]   d_type = 4'h0;
    logic [3:0]   d_zero = 4'h0;
    logic [31:0]  reg_wdata = 32'h0;
    logic [31:0]  d_count = 32'h0;
    logic [7:0]   src_byte = 8'h0;
    logic [127:0] desc_data;
    logic [31:0]  reg_rdata;
    logic [7:0]   out_byte;
    logic         desc_ready, desc_done, desc_error, desc_is_bucket, src_ready, out_valid, irq;
    int           miscompares = 0;
    int           checks_done = 0;
    sgl_bit_bucket_decoder i_dut (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .desc_valid, .desc_data, .desc_ready, .desc_done, .desc_error,
        .desc_is_bucket, .src_valid, .src_byte, .src_ready, .out_valid, .out_byte, .irq);
    host_desc_mem i_host (.desc_type(d_type), .zero_field(d_zero), .count(d_count),
        .desc_word(desc_data));
    initial forever #4 ref_clk = ~ref_clk;
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {reg_addr, reg_wdata, reg_write} <= {a, d, 1'h1};
        @(posedge ref_clk);
        reg_write <= 1'h0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge ref_clk);
        {reg_addr, reg_read} <= {a, 1'h1};
        @(posedge ref_clk);
        reg_read <= 1'h0;
        #1 chk(what, reg_rdata, exp);
    endtask
    // Sent only while no discard is pending, so each offer is taken at once
    task automatic send_desc(input logic [3:0] t, input logic [3:0] z, input logic [31:0] c,
        input logic err);
        @(posedge ref_clk);
        {d_type, d_zero, d_count, desc_valid} <= {t, z, c, 1'h1};
        @(posedge ref_clk);
        desc_valid <= 1'h0;
        #1 chk("desc flags", {desc_done, desc_error, desc_is_bucket}, {1'h1, err, t == 4'h1});
    endtask
    task automatic send_byte(input logic [7:0] b, input logic pass);
        @(posedge ref_clk);
        {src_byte, src_valid} <= {b, 1'h1};
        @(posedge ref_clk);
        src_valid <= 1'h0;
        #1 chk("out", {out_valid, out_valid ? out_byte : 8'h0}, {pass, pass ? b : 8'h0});
    endtask
    task automatic report_and_stop;
        $display("Mismatches %0d, checks %0d", miscompares, checks_done);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        reset <= 1'h0;
        rd_chk(4'h0, 32'h0, "control");
        rd_chk(4'hC, 32'h0, "mask");
        rd_chk(4'h2, 32'h0, "unmapped");
        wr(4'hC, 32'h3);
        wr(4'h0, 32'h1);
        send_desc(4'h1, 4'h0, 32'h2, 1'h0);
        chk("ready busy", {src_ready, desc_ready}, 32'h2);
        rd_chk(4'h4, 32'h2, "remaining");
        send_byte(8'h11, 1'h0);
        send_byte(8'h22, 1'h0);
        send_byte(8'h33, 1'h1);
        chk("ready idle", {src_ready, desc_ready}, 32'h3);
        chk("irq", irq, 1'h1);
        rd_chk(4'h8, 32'h1, "irq status");
        wr(4'h8, 32'h3);
        rd_chk(4'h8, 32'h0, "irq cleared");
        chk("irq low", irq, 1'h0);
        send_desc(4'h1, 4'h0, 32'h0, 1'h0);
        send_byte(8'h44, 1'h1);
        send_desc(4'h1, 4'h5, 32'h2, 1'h1);
        send_byte(8'h55, 1'h1);
        for (int t = 4; t <= 14; t++) send_desc(t[3:0], 4'h0, 32'h1, 1'h1);
        send_desc(4'h2, 4'h0, 32'h1, 1'h0);
        send_desc(4'hF, 4'h5, 32'h1, 1'h0);
        send_byte(8'h77, 1'h1);
        wr(4'h0, 32'h0);
        send_desc(4'h1, 4'h0, 32'h3, 1'h0);
        send_byte(8'h66, 1'h1);
        rd_chk(4'h8, 32'h3, "irq both");
        chk("irq set", irq, 1'h1);
        wr(4'hC, 32'h0);
        #1 chk("irq masked", irq, 1'h0);
        report_and_stop();
    end
endmodule
bind sgl_bit_bucket_decoder sgl_bit_bucket_props i_props (.ref_clk, .reset, .desc_valid,
    .desc_data, .desc_ready, .desc_done, .desc_error, .desc_is_bucket, .src_valid,
    .src_byte, .out_valid, .out_byte);
